// File: design/rsc_consts.vh
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
// clock and microsecond prescaler
`define RSC_CLK_NS 20
`define RSC_US_CYC (1000 / `RSC_CLK_NS)
`define RSC_US_LAST (`RSC_US_CYC - 1)
`define RSC_DIV_W 6
`define RSC_DIV_ZERO 6'h00
`define RSC_DIV_ONE 6'h01
// register offsets and fields
`define RSC_ADDR_STATUS 6'h01
`define RSC_ADDR_CTRL 6'h02
`define RSC_BIT_DONE 7
`define RSC_BIT_IDLE 6
`define RSC_CMD_RST 5'h00
// radio state codes
`define RSC_ST_PON 5'h00
`define RSC_ST_BUSYRX 5'h01
`define RSC_ST_TX 5'h02
`define RSC_ST_LISTEN 5'h06
`define RSC_ST_IDLE 5'h08
`define RSC_ST_SYNTH 5'h09
`define RSC_ST_SLEEP 5'h0f
`define RSC_ST_PREHIB 5'h10
`define RSC_ST_BUSYAACK 5'h11
`define RSC_ST_BUSYARET 5'h12
`define RSC_ST_AACK 5'h16
`define RSC_ST_ARET 5'h19
`define RSC_ST_HIB 5'h1e
`define RSC_ST_PEND 5'h1f
// command codes
`define RSC_CMD_NOP 5'h00
`define RSC_CMD_TX 5'h02
`define RSC_CMD_FIDLE 5'h03
`define RSC_CMD_FSYN 5'h04
`define RSC_CMD_LISTEN 5'h06
`define RSC_CMD_IDLE 5'h08
`define RSC_CMD_SYNTH 5'h09
`define RSC_CMD_PREHIB 5'h10
`define RSC_CMD_AACK 5'h16
`define RSC_CMD_ARET 5'h19
// times in microseconds, counted in microsecond ticks, then random seed and taps
`define RSC_TMR_W 10
`define RSC_T_ZERO 10'h000
`define RSC_T_ONE 10'h001
`define RSC_T_FAST 10'h001
`define RSC_T_RST 10'h01a
`define RSC_T_SYN 10'h050
`define RSC_T_SYN_IN 10'h051
`define RSC_T_RXTX 10'h010
`define RSC_T_TXRX 10'h020
`define RSC_T_HIB_RADIO_CLOCK_OUTPUT 10'h023
`define RSC_T_CF 10'h018
`define RSC_T_MEAS 10'h087
`define RSC_T_SYNC 10'h060
`define RSC_T_RSSI 2'h2
`define RSC_RND_SEED 8'h5a
`define RSC_RND_TAPS 8'hb8
`endif

// File: design/rsc_radio_state_controller.v
`timescale 1ns/100ps
`include "rsc_consts.vh"

module rsc_radio_state_controller #(
    parameter [9:0] T_PON_US = 10'h168,  // power-on to idle, microseconds
    parameter [9:0] T_WAKE_US = 10'h168, // hibernate to idle, microseconds
    parameter [9:0] T_SLP_US = 10'h0d2   // sleep to idle, microseconds
) (
    input wire clk_i,                    // 50 mhz clock
    input wire arst_n_i,                 // async reset, active low
    input wire rst_pin_n_i,              // radio reset pin, active low
    input wire sleep_transmit_pin_i,     // sleep/transmit pin
    input wire radio_clock_output_fast_i,              // clock output above 250 khz
    input wire [5:0] reg_addr_i,         // register address
    input wire reg_wr_i,                 // write strobe
    input wire reg_rd_i,                 // read strobe
    input wire [7:0] reg_wdata_i,        // write data
    output reg [7:0] reg_rdata_o,        // read data, next cycle
    input wire frame_end_i,              // transmitter finished frame
    input wire preamble_i,               // preamble seen on air
    input wire rx_end_i,                 // received frame ended
    input wire meas_req_i,               // start energy/channel check
    input wire chan_busy_i,              // channel energy above level
    input wire [2:0] trac_result_i,      // transaction result
    output reg rssi_tick_o,              // signal strength refresh pulse
    output reg meas_done_o,              // measurement finished pulse
    output reg pll_cal_o,                // frequency calibration busy
    output reg [7:0] rnd_o,              // random value
    output reg tx_active_o               // transmitter on air
);

    reg [4:0] st_ff;
    reg pend_ff;
    reg [4:0] tgt_ff;
    reg [`RSC_TMR_W-1:0] tmr_ff;
    reg [`RSC_DIV_W-1:0] tdiv_ff;
    reg [`RSC_DIV_W-1:0] gdiv_ff;
    reg dfr_ff;
    reg [4:0] cmd_ff;
    reg [2:0] trac_ff;
    reg pin_ff;
    reg [1:0] rssi_ff;
    reg [`RSC_TMR_W-1:0] cal_ff;
    reg [`RSC_TMR_W-1:0] meas_ff;
    reg done_ff;
    reg idle_ff;
    reg [`RSC_TMR_W-1:0] sync_ff;
    reg nxt_go;
    reg [4:0] nxt_tgt;
    reg [`RSC_TMR_W-1:0] nxt_t;
    reg nxt_dfr;
    wire us_tick;
    wire pin_rise;
    wire pin_fall;
    wire asleep;
    wire rx_state;
    wire tdone;
    wire cmd_wr;
    wire [4:0] wcmd;
    wire [4:0] state_code;

    // free-running microsecond tick for the periodic blocks
    assign us_tick = (gdiv_ff == `RSC_US_LAST);
    assign pin_rise = sleep_transmit_pin_i & ~pin_ff;
    assign pin_fall = ~sleep_transmit_pin_i & pin_ff;
    assign asleep = (st_ff == `RSC_ST_SLEEP) || (st_ff == `RSC_ST_HIB);
    assign rx_state = (st_ff == `RSC_ST_LISTEN) || (st_ff == `RSC_ST_BUSYRX) ||
                      (st_ff == `RSC_ST_AACK) || (st_ff == `RSC_ST_BUSYAACK);
    assign tdone = pend_ff && (tmr_ff == `RSC_T_ZERO);
    // writes are dropped while asleep and during radio reset
    assign cmd_wr = reg_wr_i && (reg_addr_i == `RSC_ADDR_CTRL) && !asleep && rst_pin_n_i;
    assign wcmd = reg_wdata_i[4:0];
    assign state_code = pend_ff ? `RSC_ST_PEND : st_ff;

    // decode a command or pin edge into a target state and settle time
    always @* begin
        nxt_go = 1'b0;
        nxt_tgt = st_ff;
        nxt_t = `RSC_T_ONE;
        nxt_dfr = 1'b0;
        if (cmd_wr && wcmd == `RSC_CMD_FIDLE) begin
            nxt_go = 1'b1;
            nxt_tgt = `RSC_ST_IDLE;
            nxt_t = `RSC_T_FAST;
        end else if (cmd_wr && !pend_ff) begin
            // commands other than forced idle are ignored while pending, host must wait
            case (wcmd)
                `RSC_CMD_FSYN: begin
                    if (st_ff != `RSC_ST_PON) begin
                        nxt_go = 1'b1;
                        nxt_tgt = `RSC_ST_SYNTH;
                        nxt_t = `RSC_T_FAST;
                    end
                end
                `RSC_CMD_IDLE: begin
                    if (st_ff == `RSC_ST_PON) begin
                        nxt_go = 1'b1;
                        nxt_tgt = `RSC_ST_IDLE;
                        nxt_t = T_PON_US;
                    end else if (st_ff != `RSC_ST_TX && st_ff != `RSC_ST_BUSYARET) begin
                        nxt_go = 1'b1;
                        nxt_tgt = `RSC_ST_IDLE;
                    end
                end
                `RSC_CMD_SYNTH: begin
                    if (st_ff == `RSC_ST_IDLE) begin
                        nxt_go = 1'b1;
                        nxt_tgt = `RSC_ST_SYNTH;
                        nxt_t = `RSC_T_SYN;
                    end else if (rx_state || st_ff == `RSC_ST_ARET) begin
                        nxt_go = 1'b1;
                        nxt_tgt = `RSC_ST_SYNTH;
                    end
                end
                `RSC_CMD_LISTEN, `RSC_CMD_AACK: begin
                    if (st_ff == `RSC_ST_TX || st_ff == `RSC_ST_BUSYARET) begin
                        nxt_dfr = 1'b1;
                    end else if (st_ff == `RSC_ST_IDLE) begin
                        nxt_go = 1'b1;
                        nxt_tgt = wcmd;
                        nxt_t = (wcmd == `RSC_CMD_AACK) ? `RSC_T_SYN_IN : `RSC_T_SYN;
                    end else if (st_ff == `RSC_ST_SYNTH || st_ff == `RSC_ST_LISTEN ||
                                 st_ff == `RSC_ST_AACK || st_ff == `RSC_ST_ARET) begin
                        nxt_go = 1'b1;
                        nxt_tgt = wcmd;
                    end
                end
                `RSC_CMD_ARET: begin
                    if (st_ff == `RSC_ST_IDLE) begin
                        nxt_go = 1'b1;
                        nxt_tgt = `RSC_ST_ARET;
                        nxt_t = `RSC_T_SYN_IN;
                    end else if (st_ff == `RSC_ST_SYNTH || rx_state) begin
                        nxt_go = 1'b1;
                        nxt_tgt = `RSC_ST_ARET;
                    end
                end
                `RSC_CMD_TX: begin
                    if (st_ff == `RSC_ST_SYNTH || st_ff == `RSC_ST_ARET) begin
                        nxt_go = 1'b1;
                        nxt_tgt = (st_ff == `RSC_ST_ARET) ? `RSC_ST_BUSYARET : `RSC_ST_TX;
                        nxt_t = `RSC_T_RXTX;
                    end
                end
                `RSC_CMD_PREHIB: begin
                    if (st_ff == `RSC_ST_IDLE) begin
                        nxt_go = 1'b1;
                        nxt_tgt = `RSC_ST_PREHIB;
                    end
                end
                default: begin
                    nxt_go = 1'b0;
                end
            endcase
        end else if (!pend_ff && rst_pin_n_i) begin
            // pin edges act only in the states that accept them
            if (pin_rise && (st_ff == `RSC_ST_SYNTH || st_ff == `RSC_ST_ARET)) begin
                nxt_go = 1'b1;
                nxt_tgt = (st_ff == `RSC_ST_ARET) ? `RSC_ST_BUSYARET : `RSC_ST_TX;
                nxt_t = `RSC_T_RXTX;
            end else if (pin_rise && (st_ff == `RSC_ST_PREHIB || st_ff == `RSC_ST_IDLE)) begin
                nxt_go = 1'b1;
                nxt_tgt = (st_ff == `RSC_ST_PREHIB) ? `RSC_ST_HIB : `RSC_ST_SLEEP;
                nxt_t = radio_clock_output_fast_i ? `RSC_T_HIB_RADIO_CLOCK_OUTPUT : `RSC_T_ZERO;
            end else if (pin_fall && st_ff == `RSC_ST_HIB) begin
                nxt_go = 1'b1;
                nxt_tgt = `RSC_ST_IDLE;
                nxt_t = T_WAKE_US;
            end else if (pin_fall && st_ff == `RSC_ST_SLEEP) begin
                nxt_go = 1'b1;
                nxt_tgt = `RSC_ST_IDLE;
                nxt_t = T_SLP_US;
            end
        end
    end

    // main state, pending target and settle timer
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_ff <= `RSC_ST_PON;
            pend_ff <= 1'b0;
            tgt_ff <= `RSC_ST_PON;
            tmr_ff <= `RSC_T_ZERO;
            tdiv_ff <= `RSC_DIV_ZERO;
            dfr_ff <= 1'b0;
            sync_ff <= `RSC_T_ZERO;
        end else if (!rst_pin_n_i) begin
            // reset drops a deferred request and starts a pending change to idle, pending or not, except in power-on, sleep and hibernate
            dfr_ff <= 1'b0;
            sync_ff <= `RSC_T_ZERO;
            tdiv_ff <= `RSC_DIV_ZERO;
            if (st_ff != `RSC_ST_PON && !asleep) begin
                pend_ff <= 1'b1;
                tgt_ff <= `RSC_ST_IDLE;
                tmr_ff <= `RSC_T_RST;
            end
        end else if (nxt_go) begin
            pend_ff <= 1'b1;
            tgt_ff <= nxt_tgt;
            tmr_ff <= nxt_t;
            tdiv_ff <= `RSC_DIV_ZERO;
            dfr_ff <= 1'b0;
            sync_ff <= `RSC_T_ZERO;
        end else if (tdone) begin
            st_ff <= tgt_ff;
            pend_ff <= 1'b0;
        end else if (pend_ff) begin
            // dedicated prescaler so each wait starts on a fresh microsecond
            if (tdiv_ff == `RSC_US_LAST) begin
                tdiv_ff <= `RSC_DIV_ZERO;
                tmr_ff <= tmr_ff - `RSC_T_ONE;
            end else begin
                tdiv_ff <= tdiv_ff + `RSC_DIV_ONE;
            end
        end else begin
            if (nxt_dfr) begin
                dfr_ff <= 1'b1;
            end
            // frame end: settle back to receive frequency
            if (frame_end_i && (st_ff == `RSC_ST_TX || st_ff == `RSC_ST_BUSYARET)) begin
                pend_ff <= 1'b1;
                tmr_ff <= `RSC_T_TXRX;
                tdiv_ff <= `RSC_DIV_ZERO;
                dfr_ff <= 1'b0;
                if (dfr_ff || nxt_dfr) begin
                    tgt_ff <= `RSC_ST_LISTEN;
                end else if (st_ff == `RSC_ST_BUSYARET) begin
                    tgt_ff <= `RSC_ST_ARET;
                end else begin
                    tgt_ff <= `RSC_ST_SYNTH;
                end
            end
            // synchronization on a detected preamble
            if ((st_ff == `RSC_ST_LISTEN || st_ff == `RSC_ST_AACK) && preamble_i) begin
                if (sync_ff == `RSC_T_SYNC) begin
                    st_ff <= (st_ff == `RSC_ST_AACK) ? `RSC_ST_BUSYAACK : `RSC_ST_BUSYRX;
                    sync_ff <= `RSC_T_ZERO;
                end else if (us_tick) begin
                    sync_ff <= sync_ff + `RSC_T_ONE;
                end
            end else begin
                sync_ff <= `RSC_T_ZERO;
            end
            if (rx_end_i && st_ff == `RSC_ST_BUSYRX) begin
                st_ff <= `RSC_ST_LISTEN;
            end
            if (rx_end_i && st_ff == `RSC_ST_BUSYAACK) begin
                st_ff <= `RSC_ST_AACK;
            end
        end
    end

    // pin history, command field and result capture
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_ff <= 1'b0;
            cmd_ff <= `RSC_CMD_RST;
            trac_ff <= 3'h0;
        end else begin
            pin_ff <= sleep_transmit_pin_i;
            trac_ff <= trac_result_i;
            if (!rst_pin_n_i) begin
                cmd_ff <= `RSC_CMD_RST;
            end else if (cmd_wr) begin
                cmd_ff <= wcmd;
            end
        end
    end

    // register reads; nothing answers while asleep
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i && !asleep && reg_addr_i == `RSC_ADDR_STATUS) begin
            reg_rdata_o <= {done_ff, idle_ff, 1'b0, state_code};
        end else if (reg_rd_i && !asleep && reg_addr_i == `RSC_ADDR_CTRL) begin
            reg_rdata_o <= {trac_ff, cmd_ff};
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // global microsecond divider, signal strength and random value
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gdiv_ff <= `RSC_DIV_ZERO;
            rssi_ff <= 2'h0;
            rssi_tick_o <= 1'b0;
            rnd_o <= `RSC_RND_SEED;
        end else begin
            gdiv_ff <= us_tick ? `RSC_DIV_ZERO : gdiv_ff + `RSC_DIV_ONE;
            rssi_tick_o <= 1'b0;
            if (us_tick) begin
                // lfsr step; zero state cannot occur from a nonzero seed
                rnd_o <= rnd_o[0] ? ((rnd_o >> 1) ^ `RSC_RND_TAPS) : (rnd_o >> 1);
                if (!rx_state) begin
                    rssi_ff <= 2'h0;
                end else if (rssi_ff == `RSC_T_RSSI - 2'h1) begin
                    rssi_ff <= 2'h0;
                    rssi_tick_o <= 1'b1;
                end else begin
                    rssi_ff <= rssi_ff + 2'h1;
                end
            end
        end
    end

    // eight-symbol energy / channel measurement in receive states
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meas_ff <= `RSC_T_ZERO;
            done_ff <= 1'b0;
            idle_ff <= 1'b0;
            meas_done_o <= 1'b0;
        end else begin
            meas_done_o <= 1'b0;
            if (!rst_pin_n_i || !rx_state) begin
                meas_ff <= `RSC_T_ZERO;
            end else if (meas_ff != `RSC_T_ZERO) begin
                if (us_tick && meas_ff == `RSC_T_ONE) begin
                    meas_ff <= `RSC_T_ZERO;
                    done_ff <= 1'b1;
                    idle_ff <= ~chan_busy_i;
                    meas_done_o <= 1'b1;
                end else if (us_tick) begin
                    meas_ff <= meas_ff - `RSC_T_ONE;
                end
            end else if (meas_req_i) begin
                // new request clears the old result; done cannot fire now
                meas_ff <= `RSC_T_MEAS;
                done_ff <= 1'b0;
                idle_ff <= 1'b0;
            end
        end
    end

    // centre-frequency calibration while the synthesizer starts
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cal_ff <= `RSC_T_ZERO;
            pll_cal_o <= 1'b0;
            tx_active_o <= 1'b0;
        end else begin
            tx_active_o <= !pend_ff && (st_ff == `RSC_ST_TX || st_ff == `RSC_ST_BUSYARET);
            pll_cal_o <= (cal_ff != `RSC_T_ZERO);
            if (nxt_go && st_ff == `RSC_ST_IDLE && nxt_t == `RSC_T_SYN) begin
                cal_ff <= `RSC_T_CF;
            end else if (nxt_go && st_ff == `RSC_ST_IDLE && nxt_t == `RSC_T_SYN_IN) begin
                cal_ff <= `RSC_T_CF;
            end else if (cal_ff != `RSC_T_ZERO && us_tick) begin
                cal_ff <= cal_ff - `RSC_T_ONE;
            end
        end
    end

endmodule // rsc_radio_state_controller

// File: testbench/rsc_chk_asserts.sv
`timescale 1ns/100ps
`include "rsc_consts.vh"
// watches the controller pins only
module rsc_chk_asserts (
    input wire clk_i,             // clock
    input wire arst_n_i,          // async reset
    input wire rst_pin_n_i,       // radio reset pin
    input wire [5:0] reg_addr_i,  // address
    input wire reg_wr_i,          // write strobe
    input wire reg_rd_i,          // read strobe
    input wire [7:0] reg_wdata_i, // write data
    input wire [7:0] reg_rdata_o, // read data
    input wire frame_end_i,       // frame finished
    input wire meas_req_i,        // measurement start
    input wire rssi_tick_o,       // strength pulse
    input wire meas_done_o,       // measurement end
    input wire pll_cal_o,         // calibration busy
    input wire [7:0] rnd_o,       // random value
    input wire tx_active_o        // on air
);
    reg [7:0] rnd_prev_ff;
    reg [5:0] rnd_cnt_ff;
    reg rnd_seen_ff;
    reg [10:0] cal_cnt_ff;

    // cycle counts; first random step is skipped since the prescaler phase is unknown
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rnd_prev_ff <= `RSC_RND_SEED;
            rnd_cnt_ff <= 6'h00;
            rnd_seen_ff <= 1'b0;
            cal_cnt_ff <= 11'h000;
        end else begin
            rnd_prev_ff <= rnd_o;
            rnd_cnt_ff <= (rnd_o != rnd_prev_ff) ? 6'h01 : rnd_cnt_ff + 6'h01;
            rnd_seen_ff <= rnd_seen_ff | (rnd_o != rnd_prev_ff);
            cal_cnt_ff <= pll_cal_o ? cal_cnt_ff + 11'h001 : 11'h000;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    a_read_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero without a read");
    a_unmapped_zero: assert property (reg_rd_i && reg_addr_i != `RSC_ADDR_STATUS && reg_addr_i != `RSC_ADDR_CTRL
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    a_status_spare: assert property (reg_rd_i && reg_addr_i == `RSC_ADDR_STATUS |=> !reg_rdata_o[5])
        else $error("status bit 5 set");
    a_state_legal: assert property (reg_rd_i && reg_addr_i == `RSC_ADDR_STATUS |=> reg_rdata_o[4:0] inside
        {5'h00, 5'h01, 5'h02, 5'h06, 5'h08, 5'h09, 5'h10, 5'h11, 5'h12, 5'h16, 5'h19, 5'h1f})
        else $error("reserved state code read");
    a_rnd_period: assert property (rnd_seen_ff && rnd_o != rnd_prev_ff |-> rnd_cnt_ff == 6'h32)
        else $error("random value step not 50 cycles");
    a_rssi_gap: assert property ($rose(rssi_tick_o) |=> !rssi_tick_o [*8])
        else $error("strength pulses too close");
    a_meas_wait: assert property (meas_req_i |=> !meas_done_o [*8])
        else $error("measurement ended too soon");
    a_tx_settle: assert property (reg_wr_i && reg_addr_i == `RSC_ADDR_CTRL && reg_wdata_i[4:0] == `RSC_CMD_TX
        && !tx_active_o |=> !tx_active_o [*8]) else $error("transmit without settling");
    // on-air flag is registered from the pending flag, so it drops two edges later
    a_tx_end: assert property (frame_end_i && tx_active_o |-> ##2 !tx_active_o)
        else $error("still on air after frame end");
    a_cal_bound: assert property (cal_cnt_ff <= 11'd1250)
        else $error("calibration too long");
    a_pin_reset: assert property (!rst_pin_n_i |-> ##2 !tx_active_o)
        else $error("on air during reset pin");

    c_tx: cover property (tx_active_o ##1 frame_end_i);
    c_meas: cover property (meas_done_o);
    c_rssi: cover property (rssi_tick_o);
endmodule // rsc_chk_asserts

bind rsc_radio_state_controller rsc_chk_asserts u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .rst_pin_n_i(rst_pin_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .frame_end_i(frame_end_i), .meas_req_i(meas_req_i),
    .rssi_tick_o(rssi_tick_o), .meas_done_o(meas_done_o), .pll_cal_o(pll_cal_o), .rnd_o(rnd_o),
    .tx_active_o(tx_active_o));

// File: testbench/rsc_host_model.sv
`timescale 1ns/100ps
`include "rsc_consts.vh"
// host side: one-cycle strobes, polls status between commands
module rsc_host_model (
    input wire clk_i,             // clock
    input wire [7:0] reg_rdata_i, // read data
    output reg [5:0] reg_addr_o,  // address
    output reg reg_wr_o,          // write strobe
    output reg reg_rd_o,          // read strobe
    output reg [7:0] reg_wdata_o  // write data
);
    // quiet bus at time zero
    initial begin
        reg_addr_o = 6'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // data is registered, so take it just after the taking edge
    task rd_reg(input [5:0] a, output [7:0] d);
        begin
            @(posedge clk_i);
            reg_addr_o <= a;
            reg_rd_o <= 1'b1;
            @(posedge clk_i);
            reg_rd_o <= 1'b0;
            #1 d = reg_rdata_i;
        end
    endtask

    // single write strobe
    task wr_reg(input [5:0] a, input [7:0] d);
        begin
            @(posedge clk_i);
            reg_addr_o <= a;
            reg_wdata_o <= d;
            reg_wr_o <= 1'b1;
            @(posedge clk_i);
            reg_wr_o <= 1'b0;
        end
    endtask

    // hold off while pending; forced idle may cut in
    task send_cmd(input [4:0] c);
        reg [7:0] v;
        integer n;
        begin
            n = 0;
            rd_reg(`RSC_ADDR_STATUS, v);
            while (v[4:0] == `RSC_ST_PEND && c != `RSC_CMD_FIDLE && n < 60000) begin
                rd_reg(`RSC_ADDR_STATUS, v);
                n = n + 1;
            end
            wr_reg(`RSC_ADDR_CTRL, {3'h0, c});
        end
    endtask

    // poll until the state matches or the budget runs out
    task wait_state(input [4:0] s, input integer lim, output [7:0] v);
        integer n;
        begin
            n = 0;
            rd_reg(`RSC_ADDR_STATUS, v);
            while (v[4:0] !== s && n < lim) begin
                rd_reg(`RSC_ADDR_STATUS, v);
                n = n + 1;
            end
        end
    endtask
endmodule // rsc_host_model

// File: testbench/rsc_radio_state_controller_test.sv
`timescale 1ns/100ps
`include "rsc_consts.vh"
module rsc_radio_state_controller_test;
    localparam [9:0] T_SHORT = 10'h003;
    reg clk_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg rst_pin_n_i = 1'b1;
    reg sleep_transmit_pin_i = 1'b0;
    reg radio_clock_output_fast_i = 1'b1;
    reg frame_end_i = 1'b0;
    reg preamble_i = 1'b0;
    reg rx_end_i = 1'b0;
    reg meas_req_i = 1'b0;
    reg chan_busy_i = 1'b0;
    reg [2:0] trac_result_i = 3'h0;
    wire [5:0] reg_addr_i;
    wire reg_wr_i, reg_rd_i, rssi_tick_o, meas_done_o, pll_cal_o, tx_active_o;
    wire [7:0] reg_wdata_i, reg_rdata_o, rnd_o;
    integer n_fail = 0;
    integer check_count = 0;
    integer n;
    reg [7:0] v;

    // 50 mhz
    always #10 clk_i = ~clk_i;

    rsc_radio_state_controller #(.T_PON_US(T_SHORT), .T_WAKE_US(T_SHORT), .T_SLP_US(T_SHORT)) u_dut (
        .clk_i(clk_i), .arst_n_i(arst_n_i), .rst_pin_n_i(rst_pin_n_i),
        .sleep_transmit_pin_i(sleep_transmit_pin_i), .radio_clock_output_fast_i(radio_clock_output_fast_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .frame_end_i(frame_end_i), .preamble_i(preamble_i), .rx_end_i(rx_end_i), .meas_req_i(meas_req_i),
        .chan_busy_i(chan_busy_i), .trac_result_i(trac_result_i), .rssi_tick_o(rssi_tick_o),
        .meas_done_o(meas_done_o), .pll_cal_o(pll_cal_o), .rnd_o(rnd_o), .tx_active_o(tx_active_o));

    rsc_host_model u_host (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i));

    task check(input string name, input [7:0] seen, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected %s: expected %h, seen %h", name, exp, seen);
            end
        end
    endtask

    // command, then poll with a budget of about us microseconds
    task go(input [4:0] c, input [4:0] s, input integer us);
        begin
            u_host.send_cmd(c);
            u_host.wait_state(s, us * 25 + 60, v);
            check("state", {3'h0, v[4:0]}, {3'h0, s});
        end
    endtask

    task stop_test;
        begin
            $display("checks %0d, mismatches %0d", check_count, n_fail);
            if (n_fail == 0 && check_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // cut a hang short
    initial begin
        repeat (90000) @(posedge clk_i);
        n_fail = n_fail + 1;
        stop_test;
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        #1 check("random", rnd_o, `RSC_RND_SEED);
        u_host.rd_reg(`RSC_ADDR_CTRL, v);
        check("control", v, 8'h00);
        u_host.rd_reg(`RSC_ADDR_STATUS, v);
        check("status", v, 8'h00);
        u_host.rd_reg(6'h3f, v);
        check("unmapped", v, 8'h00);
        u_host.wr_reg(`RSC_ADDR_CTRL, {3'h0, `RSC_CMD_IDLE});
        u_host.rd_reg(`RSC_ADDR_STATUS, v);
        check("status", v, {3'h0, `RSC_ST_PEND});
        u_host.wait_state(`RSC_ST_IDLE, 5 * 25 + 60, v);
        check("status", v, {3'h0, `RSC_ST_IDLE});
        trac_result_i <= 3'h6;
        u_host.wr_reg(`RSC_ADDR_CTRL, 8'h05);
        u_host.rd_reg(`RSC_ADDR_CTRL, v);
        check("control", v, 8'hc5);
        u_host.rd_reg(`RSC_ADDR_STATUS, v);
        check("status", v, {3'h0, `RSC_ST_IDLE});
        u_host.send_cmd(`RSC_CMD_SYNTH);
        @(posedge clk_i) #1 check("calibrate", {7'h0, pll_cal_o}, 8'h01);
        go(`RSC_CMD_NOP, `RSC_ST_SYNTH, 82);
        go(`RSC_CMD_TX, `RSC_ST_TX, 18);
        check("on air", {7'h0, tx_active_o}, 8'h01);
        // receive request while on air is held until the frame ends
        u_host.send_cmd(`RSC_CMD_LISTEN);
        @(posedge clk_i) frame_end_i <= 1'b1;
        @(posedge clk_i) frame_end_i <= 1'b0;
        u_host.wait_state(`RSC_ST_LISTEN, 34 * 25 + 60, v);
        check("status", v, {3'h0, `RSC_ST_LISTEN});
        for (n = 0; n < 120 && rssi_tick_o !== 1'b1; n = n + 1)
            @(posedge clk_i) #1;
        check("strength", {7'h0, rssi_tick_o}, 8'h01);
        @(posedge clk_i) meas_req_i <= 1'b1;
        @(posedge clk_i) meas_req_i <= 1'b0;
        for (n = 0; n < 6950 && meas_done_o !== 1'b1; n = n + 1)
            @(posedge clk_i) #1;
        check("measure", {7'h0, meas_done_o}, 8'h01);
        u_host.rd_reg(`RSC_ADDR_STATUS, v);
        check("flags", {6'h0, v[7:6]}, 8'h03);
        preamble_i <= 1'b1;
        u_host.wait_state(`RSC_ST_BUSYRX, 98 * 25 + 60, v);
        check("status", {3'h0, v[4:0]}, {3'h0, `RSC_ST_BUSYRX});
        preamble_i <= 1'b0;
        @(posedge clk_i) rx_end_i <= 1'b1;
        @(posedge clk_i) rx_end_i <= 1'b0;
        u_host.wait_state(`RSC_ST_LISTEN, 60, v);
        check("status", {3'h0, v[4:0]}, {3'h0, `RSC_ST_LISTEN});
        go(`RSC_CMD_FIDLE, `RSC_ST_IDLE, 2);
        go(`RSC_CMD_FSYN, `RSC_ST_SYNTH, 2);
        // reset pin mid-run
        @(posedge clk_i) rst_pin_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_pin_n_i <= 1'b1;
        u_host.rd_reg(`RSC_ADDR_STATUS, v);
        check("status", {3'h0, v[4:0]}, {3'h0, `RSC_ST_PEND});
        u_host.wait_state(`RSC_ST_IDLE, 28 * 25 + 60, v);
        check("status", {3'h0, v[4:0]}, {3'h0, `RSC_ST_IDLE});
        u_host.rd_reg(`RSC_ADDR_CTRL, v);
        check("control", v, 8'hc0);
        // pin rise in idle sleeps, pin low wakes
        @(posedge clk_i) sleep_transmit_pin_i <= 1'b1;
        repeat (2000) @(posedge clk_i);
        u_host.rd_reg(`RSC_ADDR_STATUS, v);
        check("asleep", v, 8'h00);
        sleep_transmit_pin_i <= 1'b0;
        u_host.wait_state(`RSC_ST_IDLE, 6 * 25 + 60, v);
        check("status", {3'h0, v[4:0]}, {3'h0, `RSC_ST_IDLE});
        go(`RSC_CMD_PREHIB, `RSC_ST_PREHIB, 2);
        // slow clock output: hibernate entry takes no ticks
        radio_clock_output_fast_i <= 1'b0;
        @(posedge clk_i) sleep_transmit_pin_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        u_host.rd_reg(`RSC_ADDR_STATUS, v);
        check("hibernate", v, 8'h00);
        sleep_transmit_pin_i <= 1'b0;
        u_host.wait_state(`RSC_ST_IDLE, 6 * 25 + 60, v);
        check("status", {3'h0, v[4:0]}, {3'h0, `RSC_ST_IDLE});
        stop_test;
    end
endmodule // rsc_radio_state_controller_test
